// File: common/stop_seq_defs.vh
// stop sequencer constants: field widths, reset values, timing counts
// assumes a 25 MHz control clock; parameter units are 0.1 s and 0.01 %
`ifndef STOP_SEQ_DEFS_VH
`define STOP_SEQ_DEFS_VH

// ****************************************************************
// clock and tick timing
// ****************************************************************
`define CLK_HZ            25000000
`define TICK_MS           1
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define TENTH_S_TICKS     100
`define TICK_LAST         16'h61A7
`define TENTH_LAST_MS     7'h63

// ****************************************************************
// widths and scaling
// ****************************************************************
`define SPD_W             16
`define TIME_W            13
`define PCT_W             15
`define ACC_W             32
`define FULL_SPEED        16'h2710
`define QUENCH_GATE_PCT   15'h0019

// ****************************************************************
// reset values of settings
// ****************************************************************
`define RST_NORM_RAMP     13'h0064
`define RST_NORM_TMO      13'h0000
`define RST_HOLD_TIME     13'h000A
`define RST_QUENCH_RATE   15'h0000
`define RST_FAST_RAMP     13'h0001
`define RST_FAST_TMO      13'h0258
`define RST_FAST_ILIM     15'h2710
`define RST_ZERO_THR      15'h00C8
`define RST_NORM_ILIM     15'h2710

// ****************************************************************
// register map
// ****************************************************************
`define ADDR_W            4
`define REG_NORM_RAMP     4'h0
`define REG_NORM_TMO      4'h1
`define REG_HOLD_TIME     4'h2
`define REG_QUENCH_RATE   4'h3
`define REG_FAST_RAMP     4'h4
`define REG_FAST_TMO      4'h5
`define REG_FAST_ILIM     4'h6
`define REG_ZERO_THR      4'h7
`define REG_NORM_ILIM     4'h8
`define REG_STATUS        4'h9
`define REG_DEMAND        4'hA

`endif

// File: rtl/tenth_timer.v
// tenth-of-second down timer used for stop timeouts and contactor hold
// assumes tick_en pulses once per millisecond
`timescale 1ns/1ps
`include "stop_seq_defs.vh"

module tenth_timer (
  ref_clk,
  reset,
  clk_en,
  tick_en,
  start,
  clear,
  load_val,
  running_q,
  done_q
);
  input                  ref_clk;
  input                  reset;
  input                  clk_en;
  input                  tick_en;
  input                  start;
  input                  clear;
  input  [`TIME_W-1:0]   load_val;
  output reg             running_q;
  output reg             done_q;

  reg [`TIME_W-1:0] tenths_q;
  reg [6:0]         ms_q;

  // counts down tenths; done holds until clear or restart
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tenths_q  <= 13'h0000;
      ms_q      <= 7'h00;
      running_q <= 1'b0;
      done_q    <= 1'b0;
    end else if (clk_en) begin
      if (clear) begin
        running_q <= 1'b0;
        done_q    <= 1'b0;
      end else if (start) begin
        tenths_q  <= load_val;
        ms_q      <= 7'h00;
        running_q <= (load_val != 13'h0000);
        done_q    <= (load_val == 13'h0000);
      end else if (running_q && tick_en) begin
        if (ms_q == `TENTH_LAST_MS) begin
          ms_q <= 7'h00;
          if (tenths_q == 13'h0001) begin
            running_q <= 1'b0;
            done_q    <= 1'b1;
          end
          tenths_q <= tenths_q - 13'h0001;
        end else begin
          ms_q <= ms_q + 7'h01;
        end
      end
    end
  end
endmodule // tenth_timer

// File: rtl/motor_stop_sequencer.v
// motor stop sequencer: stop hierarchy, ramps, timeouts, contactor hold
// assumes synchronous terminal inputs (high = asserted/healthy) on ref_clk
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "stop_seq_defs.vh"

module motor_stop_sequencer (
  ref_clk,
  reset,
  clk_en,
  run_terminal,
  fast_stop_terminal,
  freewheel_terminal,
  enable_terminal,
  speed_setpoint,
  speed_feedback,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata_q,
  speed_demand_q,
  current_limit_q,
  current_quench_rate_q,
  loops_enable_q,
  loops_reset_q,
  contactor_pilot_q,
  drive_enable_q
);
  input                  ref_clk;
  input                  reset;
  input                  clk_en;
  input                  run_terminal;
  input                  fast_stop_terminal;
  input                  freewheel_terminal;  // low = freewheel stop
  input                  enable_terminal;
  input  [`SPD_W-1:0]    speed_setpoint;
  input  [`SPD_W-1:0]    speed_feedback;
  input  [`ADDR_W-1:0]   reg_addr;
  input  [15:0]          reg_wdata;
  input                  reg_wr;
  input                  reg_rd;
  output reg [15:0]      reg_rdata_q;
  output reg [`SPD_W-1:0] speed_demand_q;
  output reg [`PCT_W-1:0] current_limit_q;
  output reg [`PCT_W-1:0] current_quench_rate_q;
  output reg             loops_enable_q;
  output reg             loops_reset_q;
  output reg             contactor_pilot_q;
  output reg             drive_enable_q;

  // ****************************************************************
  // states
  // ****************************************************************
  localparam ST_IDLE  = 3'd0;
  localparam ST_RUN   = 3'd1;
  localparam ST_NSTOP = 3'd2;
  localparam ST_FSTOP = 3'd3;
  localparam ST_HOLD  = 3'd4;
  localparam ST_OFF   = 3'd5;

  reg [2:0]          state_q;
  reg [2:0]          state_d;
  reg [`TIME_W-1:0]  norm_ramp_q;
  reg [`TIME_W-1:0]  norm_tmo_q;
  reg [`TIME_W-1:0]  hold_time_q;
  reg [`PCT_W-1:0]   quench_rate_q;
  reg [`TIME_W-1:0]  fast_ramp_q;
  reg [`TIME_W-1:0]  fast_tmo_q;
  reg [`PCT_W-1:0]   fast_ilim_q;
  reg [`PCT_W-1:0]   zero_thr_q;
  reg [`PCT_W-1:0]   norm_ilim_q;
  reg [15:0]         tick_cnt_q;
  reg                tick_q;
  reg [`ACC_W-1:0]   ramp_acc_q;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // feedback below a threshold (units of 0.01 %)
  function below_thr;
    input [`SPD_W-1:0] spd;
    input [`PCT_W-1:0] thr;
    begin
      below_thr = (spd < {1'b0, thr});
    end
  endfunction

  // ramp step per ms in 1/1000 of 0.01 %: full speed over ramp tenths
  function [`ACC_W-1:0] ramp_step;
    input [`TIME_W-1:0] tenths;
    begin
      ramp_step = (32'd10000 * 32'd10) / {19'h0, tenths};
    end
  endfunction

  // accumulator tops out at full scale times 1000, so the quotient fits the demand width
  wire [`ACC_W-1:0] ramp_demand = ramp_acc_q / 32'h0000_03E8;
  wire at_zero      = below_thr(speed_feedback, zero_thr_q);
  wire norm_done, fast_done, hold_done;
  wire quench_gate  = (zero_thr_q > `QUENCH_GATE_PCT) && (quench_rate_q != 15'h0000);

  // ****************************************************************
  // register bus
  // ****************************************************************
  // writes steer settings; reads show settings and live state
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      norm_ramp_q   <= `RST_NORM_RAMP;
      norm_tmo_q    <= `RST_NORM_TMO;
      hold_time_q   <= `RST_HOLD_TIME;
      quench_rate_q <= `RST_QUENCH_RATE;
      fast_ramp_q   <= `RST_FAST_RAMP;
      fast_tmo_q    <= `RST_FAST_TMO;
      fast_ilim_q   <= `RST_FAST_ILIM;
      zero_thr_q    <= `RST_ZERO_THR;
      norm_ilim_q   <= `RST_NORM_ILIM;
      reg_rdata_q   <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata_q <= 16'h0000;
      if (reg_wr) begin
        case (reg_addr)
          `REG_NORM_RAMP:   norm_ramp_q   <= (reg_wdata[12:0] == 13'h0000) ? 13'h0001
                                              : reg_wdata[12:0];
          `REG_NORM_TMO:    norm_tmo_q    <= reg_wdata[12:0];
          `REG_HOLD_TIME:   hold_time_q   <= (reg_wdata[12:0] == 13'h0000) ? 13'h0001
                                              : reg_wdata[12:0];
          `REG_QUENCH_RATE: quench_rate_q <= reg_wdata[14:0];
          `REG_FAST_RAMP:   fast_ramp_q   <= (reg_wdata[12:0] == 13'h0000) ? 13'h0001
                                              : reg_wdata[12:0];
          `REG_FAST_TMO:    fast_tmo_q    <= reg_wdata[12:0];
          `REG_FAST_ILIM:   fast_ilim_q   <= reg_wdata[14:0];
          `REG_ZERO_THR:    zero_thr_q    <= reg_wdata[14:0];
          `REG_NORM_ILIM:   norm_ilim_q   <= reg_wdata[14:0];
          default: ;
        endcase
      end else if (reg_rd) begin
        case (reg_addr)
          `REG_NORM_RAMP:   reg_rdata_q <= {3'h0, norm_ramp_q};
          `REG_NORM_TMO:    reg_rdata_q <= {3'h0, norm_tmo_q};
          `REG_HOLD_TIME:   reg_rdata_q <= {3'h0, hold_time_q};
          `REG_QUENCH_RATE: reg_rdata_q <= {1'b0, quench_rate_q};
          `REG_FAST_RAMP:   reg_rdata_q <= {3'h0, fast_ramp_q};
          `REG_FAST_TMO:    reg_rdata_q <= {3'h0, fast_tmo_q};
          `REG_FAST_ILIM:   reg_rdata_q <= {1'b0, fast_ilim_q};
          `REG_ZERO_THR:    reg_rdata_q <= {1'b0, zero_thr_q};
          `REG_NORM_ILIM:   reg_rdata_q <= {1'b0, norm_ilim_q};
          `REG_STATUS:      reg_rdata_q <= {9'h000, at_zero, drive_enable_q,
                                            contactor_pilot_q, loops_enable_q, state_q};
          `REG_DEMAND:      reg_rdata_q <= speed_demand_q;
          default:          reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (clk_en) begin
      tick_q <= (tick_cnt_q == `TICK_LAST);
      if (tick_cnt_q == `TICK_LAST)
        tick_cnt_q <= 16'h0000;
      else
        tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  tenth_timer u_norm_tmo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .tick_en   (tick_q),
    .start     (state_q == ST_RUN && state_d == ST_NSTOP),
    .clear     (state_d != ST_NSTOP),
    .load_val  (norm_tmo_q),
    .running_q (),
    .done_q    (norm_done)
  );

  tenth_timer u_fast_tmo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .tick_en   (tick_q),
    .start     (state_q != ST_FSTOP && state_d == ST_FSTOP),
    .clear     (state_d != ST_FSTOP),
    .load_val  (fast_tmo_q),
    .running_q (),
    .done_q    (fast_done)
  );

  tenth_timer u_hold (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .tick_en   (tick_q),
    .start     (state_q == ST_NSTOP && state_d == ST_HOLD),
    .clear     (!enable_terminal),
    .load_val  (hold_time_q),
    .running_q (),
    .done_q    (hold_done)
  );

  // ****************************************************************
  // stop state machine, priority order
  // ****************************************************************
  always @* begin
    state_d = state_q;
    if (!freewheel_terminal) begin
      state_d = ST_OFF;
    end else if (!enable_terminal) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_IDLE, ST_OFF: begin
          if (run_terminal && fast_stop_terminal)
            state_d = ST_RUN;
          else
            state_d = ST_OFF;
        end
        ST_RUN: begin
          if (!fast_stop_terminal)
            state_d = ST_FSTOP;
          else if (!run_terminal)
            state_d = ST_NSTOP;
        end
        ST_NSTOP: begin
          if (!fast_stop_terminal)
            state_d = ST_FSTOP;
          else if (norm_done)
            state_d = ST_OFF;
          else if (at_zero && speed_demand_q == 16'h0000)
            state_d = ST_HOLD;
        end
        ST_FSTOP: begin
          if (fast_done || at_zero)
            state_d = ST_OFF;
        end
        ST_HOLD: begin
          if (hold_done)
            state_d = ST_OFF;
        end
        default: state_d = ST_OFF;
      endcase
    end
  end

  // ****************************************************************
  // outputs and ramp
  // ****************************************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q               <= ST_IDLE;
      ramp_acc_q            <= 32'h0000_0000;
      speed_demand_q        <= 16'h0000;
      current_limit_q       <= 15'h0000;
      current_quench_rate_q <= `RST_QUENCH_RATE;
      loops_enable_q        <= 1'b0;
      loops_reset_q         <= 1'b1;
      contactor_pilot_q     <= 1'b0;
      drive_enable_q        <= 1'b0;
    end else if (clk_en) begin
      state_q               <= state_d;
      current_quench_rate_q <= quench_rate_q;
      // ramp accumulator holds demand scaled by 1000
      if (state_d == ST_RUN) begin
        ramp_acc_q <= {16'h0000, speed_setpoint} * 32'd1000;
      end else if ((state_d == ST_NSTOP || state_d == ST_FSTOP) && tick_q) begin
        if (ramp_acc_q > ramp_step(state_d == ST_FSTOP ? fast_ramp_q : norm_ramp_q))
          ramp_acc_q <= ramp_acc_q
                        - ramp_step(state_d == ST_FSTOP ? fast_ramp_q : norm_ramp_q);
        else
          ramp_acc_q <= 32'h0000_0000;
      end else if (state_d == ST_HOLD || state_d == ST_OFF) begin
        ramp_acc_q <= 32'h0000_0000;
      end
      speed_demand_q <= (state_d == ST_RUN) ? speed_setpoint
                        : (state_d == ST_HOLD || state_d == ST_OFF) ? 16'h0000
                        : ramp_demand[`SPD_W-1:0];
      current_limit_q <= (state_d == ST_FSTOP) ? fast_ilim_q : norm_ilim_q;
      contactor_pilot_q <= (state_d == ST_RUN || state_d == ST_NSTOP ||
                            state_d == ST_FSTOP || state_d == ST_HOLD);
      drive_enable_q <= (state_d == ST_RUN || state_d == ST_NSTOP || state_d == ST_FSTOP ||
                         (state_d == ST_HOLD && !quench_gate));
      loops_enable_q <= (state_d == ST_RUN || state_d == ST_NSTOP ||
                         state_d == ST_FSTOP || (state_d == ST_HOLD && !quench_gate));
      loops_reset_q  <= !enable_terminal;
    end
  end
endmodule // motor_stop_sequencer

// File: verif/speed_loop_model.sv
// speed loop and motor model on the far side of the stop sequencer
// assumes demand and drive enable come from the sequencer on ref_clk
`timescale 1ns/1ps
`include "stop_seq_defs.vh"
module speed_loop_model (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              slow,
  input  wire logic [`SPD_W-1:0] demand,
  input  wire logic              drive_on,
  output logic      [`SPD_W-1:0] feedback
);
  // ****************************************************************
  // motor response
  // ****************************************************************
  // prompt mode copies demand; slow mode slews one count a cycle
  // a disabled drive lets the motor coast down one count a cycle
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      feedback <= 16'h0000;
    end else if (!drive_on) begin
      if (feedback != 16'h0000) feedback <= feedback - 16'h0001;
    end else if (!slow || feedback == demand) begin
      feedback <= demand;
    end else if (feedback < demand) begin
      feedback <= feedback + 16'h0001;
    end else begin
      feedback <= feedback - 16'h0001;
    end
  end
endmodule // speed_loop_model

// File: verif/motor_stop_sequencer_asserts.sv
// port checker for the motor stop sequencer
// assumes one clock domain and the register map of stop_seq_defs.vh
`timescale 1ns/1ps
`include "stop_seq_defs.vh"
module stop_seq_checker (
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire logic               clk_en,
  input wire logic               run_terminal,
  input wire logic               fast_stop_terminal,
  input wire logic               freewheel_terminal,
  input wire logic               enable_terminal,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata_q,
  input wire logic [`SPD_W-1:0]  speed_demand_q,
  input wire logic [`PCT_W-1:0]  current_quench_rate_q,
  input wire logic               loops_enable_q,
  input wire logic               loops_reset_q,
  input wire logic               contactor_pilot_q,
  input wire logic               drive_enable_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****************************************************************
  // stop hierarchy
  // ****************************************************************
  a_freewheel_open: assert property (
    !freewheel_terminal [*3] |-> !contactor_pilot_q && !drive_enable_q)
    else $error("freewheel stop left contactor or drive on");
  a_enable_reset: assert property (
    !enable_terminal [*3] |-> loops_reset_q && !loops_enable_q)
    else $error("loops not reset with enable removed");
  a_fast_stays_off: assert property (
    !fast_stop_terminal && !drive_enable_q |=> !drive_enable_q)
    else $error("drive came on during fast stop");
  a_stop_no_rise: assert property (
    !run_terminal [*2] |-> speed_demand_q <= $past(speed_demand_q))
    else $error("demand rose while stopping");
  a_freeze_hold: assert property (
    !clk_en |=> $stable(speed_demand_q) && $stable(drive_enable_q))
    else $error("outputs moved with clock enable low");
  // ****************************************************************
  // register port
  // ****************************************************************
  a_quench_copy: assert property (
    reg_wr && clk_en && reg_addr == `REG_QUENCH_RATE
    |-> ##3 current_quench_rate_q == $past(reg_wdata[14:0], 3))
    else $error("quench rate output not the written value");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    reg_rd && clk_en && reg_addr > `REG_DEMAND |=> reg_rdata_q == 16'h0000)
    else $error("unmapped read not zero");
  a_status_bits: assert property (
    reg_rd && clk_en && reg_addr == `REG_STATUS
    |=> reg_rdata_q[5:3] == $past({drive_enable_q, contactor_pilot_q, loops_enable_q}))
    else $error("status bits differ from outputs");
  c_fast_stop: cover property (!fast_stop_terminal && drive_enable_q);
  c_freewheel: cover property (!freewheel_terminal && contactor_pilot_q);
  c_status: cover property (reg_rd && reg_addr == `REG_STATUS);
endmodule // stop_seq_checker

bind motor_stop_sequencer stop_seq_checker u_chk (
  .ref_clk, .reset, .clk_en, .run_terminal, .fast_stop_terminal,
  .freewheel_terminal, .enable_terminal, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_q, .speed_demand_q, .current_quench_rate_q,
  .loops_enable_q, .loops_reset_q, .contactor_pilot_q, .drive_enable_q
);

// File: verif/motor_stop_sequencer_tb.sv
// self-checking bench for the motor stop sequencer
// assumes the design, speed_loop_model and checker are compiled first
`timescale 1ns/1ps
`include "stop_seq_defs.vh"
module motor_stop_sequencer_tb;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic        slow = 1'b0;
  logic        run_terminal = 1'b0;
  logic        fast_stop_terminal = 1'b1;
  logic        freewheel_terminal = 1'b1;
  logic        enable_terminal = 1'b1;
  logic [15:0] speed_setpoint = 16'h0032;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rd_d;
  logic [3:0]  reg_addr = 4'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [15:0] speed_feedback, reg_rdata_q, speed_demand_q;
  wire  [14:0] current_limit_q, current_quench_rate_q;
  wire         loops_enable_q, loops_reset_q, contactor_pilot_q, drive_enable_q;
  int          err_total = 0;
  int          samples_checked = 0;
  int          n;
  logic [15:0] rv [8] = '{16'h0064, 16'h0000, 16'h000A, 16'h0000,
                          16'h0001, 16'h0258, 16'h2710, 16'h00C8};

  motor_stop_sequencer dut (
    .ref_clk, .reset, .clk_en, .run_terminal, .fast_stop_terminal,
    .freewheel_terminal, .enable_terminal, .speed_setpoint, .speed_feedback,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .speed_demand_q,
    .current_limit_q, .current_quench_rate_q, .loops_enable_q, .loops_reset_q,
    .contactor_pilot_q, .drive_enable_q
  );
  speed_loop_model u_motor (
    .ref_clk, .reset, .slow, .demand(speed_demand_q), .drive_on(drive_enable_q),
    .feedback(speed_feedback)
  );

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic chkb(input string what, input logic seen, input logic exp);
    chk(what, {15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_d = reg_rdata_q;
  endtask
  task automatic go_run();
    @(posedge ref_clk);
    run_terminal <= 1'b1;
    for (n = 0; n < 40000 && speed_demand_q !== speed_setpoint; n++) tick();
    chkb("run drive", drive_enable_q, 1'b1);
    chkb("run pilot", contactor_pilot_q, 1'b1);
    chk("run demand", speed_demand_q, speed_setpoint);
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values, unmapped reads, refused zero, quench copy
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rd(i[3:0]);
      chk("reset value", rd_d, rv[i]);
    end
    rd(4'hB);
    chk("unmapped read", rd_d, 16'h0000);
    wr(4'hF, 16'h1234);
    rd(4'hF);
    chk("unmapped write", rd_d, 16'h0000);
    wr(`REG_NORM_RAMP, 16'h0000);
    rd(`REG_NORM_RAMP);
    chk("ramp floor", rd_d, 16'h0001);
    wr(`REG_QUENCH_RATE, 16'h4E20);
    repeat (3) tick();
    chk("quench out", {1'b0, current_quench_rate_q}, 16'h4E20);
    wr(`REG_ZERO_THR, 16'h000A);
    wr(`REG_FAST_ILIM, 16'h3A98);
    wr(`REG_NORM_ILIM, 16'h2710);
  endtask
  // frozen clock enable, then fast stop with its own limit, then blocked run
  task automatic t_fast_stop();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    run_terminal <= 1'b1;
    repeat (20) tick();
    chkb("frozen drive", drive_enable_q, 1'b0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    go_run();
    chk("normal limit", {1'b0, current_limit_q}, 16'h2710);
    @(posedge ref_clk);
    fast_stop_terminal <= 1'b0;
    repeat (3) tick();
    chk("fast limit", {1'b0, current_limit_q}, 16'h3A98);
    for (n = 0; n < 30000 && contactor_pilot_q; n++) tick();
    chkb("fast pilot", contactor_pilot_q, 1'b0);
    chkb("fast drive", drive_enable_q, 1'b0);
    repeat (50) tick();
    chkb("run blocked", drive_enable_q, 1'b0);
    @(posedge ref_clk);
    fast_stop_terminal <= 1'b1;
    run_terminal <= 1'b0;
    repeat (5) tick();
  endtask
  // freewheel and fast stop together: freewheel wins at once
  task automatic t_freewheel();
    go_run();
    @(posedge ref_clk);
    freewheel_terminal <= 1'b0;
    fast_stop_terminal <= 1'b0;
    repeat (3) tick();
    chkb("coast pilot", contactor_pilot_q, 1'b0);
    chkb("coast drive", drive_enable_q, 1'b0);
    @(posedge ref_clk);
    freewheel_terminal <= 1'b1;
    fast_stop_terminal <= 1'b1;
    run_terminal <= 1'b0;
    repeat (5) tick();
  endtask
  // enable removal suspends the loops
  task automatic t_enable();
    go_run();
    @(posedge ref_clk);
    enable_terminal <= 1'b0;
    repeat (3) tick();
    chkb("loops on", loops_enable_q, 1'b0);
    chkb("loops reset", loops_reset_q, 1'b1);
    rd(`REG_STATUS);
    chk("status loops", {15'h0000, rd_d[3]}, 16'h0000);
    @(posedge ref_clk);
    enable_terminal <= 1'b1;
    run_terminal <= 1'b0;
    repeat (5) tick();
  endtask
  // normal ramp rate, contactor hold, quench gate, enable cancel, then zero timeout
  task automatic t_normal_stop();
    wr(`REG_NORM_RAMP, 16'h0004);
    wr(`REG_NORM_TMO, 16'h0001);
    @(posedge ref_clk);
    slow <= 1'b1;
    go_run();
    @(posedge ref_clk);
    run_terminal <= 1'b0;
    for (n = 0; n < 26000 && speed_demand_q === speed_setpoint; n++) tick();
    chk("ramp step", speed_demand_q, 16'h0019);
    for (n = 0; n < 26000 && speed_demand_q !== 16'h0000; n++) tick();
    repeat (100) tick();
    chkb("hold pilot", contactor_pilot_q, 1'b1);
    chkb("hold drive", drive_enable_q, 1'b1);
    chk("hold demand", speed_demand_q, 16'h0000);
    rd(`REG_STATUS);
    chk("hold state", {13'h0000, rd_d[2:0]}, 16'h0004);
    wr(`REG_ZERO_THR, 16'h001A);
    repeat (2) tick();
    chkb("gated drive", drive_enable_q, 1'b0);
    chkb("gated pilot", contactor_pilot_q, 1'b1);
    @(posedge ref_clk);
    enable_terminal <= 1'b0;
    repeat (3) tick();
    chkb("hold cancel", contactor_pilot_q, 1'b0);
    @(posedge ref_clk);
    enable_terminal <= 1'b1;
    wr(`REG_ZERO_THR, 16'h000A);
    wr(`REG_NORM_TMO, 16'h0000);
    go_run();
    @(posedge ref_clk);
    run_terminal <= 1'b0;
    repeat (3) tick();
    chkb("timeout coast", drive_enable_q, 1'b0);
    chkb("timeout pilot", contactor_pilot_q, 1'b0);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_fast_stop();
    t_freewheel();
    t_enable();
    t_normal_stop();
    end_sim();
  end

  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
endmodule // motor_stop_sequencer_tb
